// file: afe_cfg_pkg.sv
// constants for the main configuration register bank
package afe_cfg_pkg;

    // ------------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------------
    localparam int        ADDR_W        = 8;
    localparam int        DATA_W        = 32;
    localparam int        REG_W         = 8;
    localparam int        IDX_LOCK      = 0;
    localparam int        IDX_CFG_ONE   = 1;
    localparam int        IDX_CFG_TWO   = 2;
    localparam bit [7:0]  ADDR_LOCK     = 8'(4 * IDX_LOCK);
    localparam bit [7:0]  ADDR_CFG_ONE  = 8'(4 * IDX_CFG_ONE);
    localparam bit [7:0]  ADDR_CFG_TWO  = 8'(4 * IDX_CFG_TWO);

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam bit [7:0]  LOCK_RST      = 8'h01;
    localparam bit [7:0]  CFG_ONE_RST   = 8'h40;
    localparam bit [7:0]  CFG_TWO_RST   = 8'hC2;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int        LOCK_BIT      = 0;
    localparam int        SER_MODE_BIT  = 7;
    localparam int        PLL_CAL_BIT   = 6;
    localparam int        GAIN_CAL_BIT  = 5;
    localparam int        RST_FSM_BIT   = 4;
    localparam int        RST_ALL_BIT   = 3;
    localparam int        AMP_PD_BIT    = 2;
    localparam int        REF_PD_BIT    = 1;
    localparam int        MASTER_PD_BIT = 0;
    localparam int        CH_MODE_LSB   = 6;
    localparam int        COLOR_LSB     = 4;
    localparam int        ORDER_BIT     = 3;
    localparam int        MULT_BIT      = 2;
    localparam int        CDS_BIT       = 1;
    localparam int        EVEN_ODD_BIT  = 0;

    // ------------------------------------------------------------------
    // field codes
    // ------------------------------------------------------------------
    localparam bit [1:0]  MODE_THREE    = 2'h3;
    localparam bit [1:0]  MODE_TWO      = 2'h2;
    localparam bit [1:0]  MODE_ONE      = 2'h1;
    localparam bit [1:0]  COLOR_RG      = 2'h0;
    localparam bit [1:0]  COLOR_GB      = 2'h1;
    localparam bit [1:0]  COLOR_RB      = 2'h2;
    localparam bit [1:0]  FACTOR_ONE    = 2'h1;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int        CLK_PERIOD_PS = 5000;
    localparam int        CAL_TIME_NS   = 10000;
    localparam int        CAL_CYCLES    =
        (CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int        CAL_CNT_W     = 12;

endpackage

// file: afe_ctrl_if.sv
// carrier between the register bank and its calibration and decode helpers
`timescale 1ns/1ps
interface afe_ctrl_if;
    logic       clear;
    logic       cal_start;
    logic       cal_busy;
    logic [7:0] cfg_two;
    logic [2:0] input_en;
    logic       reverse;
    logic       mult_en;
    logic [1:0] factor;
    logic       cds;
    logic       even_odd;

    modport ctrl (output clear, output cal_start, output cfg_two,
                  input cal_busy, input input_en, input reverse,
                  input mult_en, input factor, input cds, input even_odd);
    modport cal  (input clear, input cal_start, output cal_busy);
    modport dec  (input cfg_two, output input_en, output reverse,
                  output mult_en, output factor, output cds,
                  output even_odd);
endinterface

// file: afe_cal_sequencer.sv
// gain and offset calibration sequencer
`timescale 1ns/1ps
module afe_cal_sequencer
(
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    afe_ctrl_if.cal   ctl
);
    typedef enum logic [1:0]
    {
        CAL_IDLE = 2'b01,
        CAL_RUN  = 2'b10
    } cal_state_t;

    typedef struct packed
    {
        cal_state_t                          state;
        logic [afe_cfg_pkg::CAL_CNT_W-1:0]   count;
    } cal_regs_t;

    localparam logic [afe_cfg_pkg::CAL_CNT_W-1:0] CNT_LAST =
        afe_cfg_pkg::CAL_CNT_W'(afe_cfg_pkg::CAL_CYCLES - 1);

    cal_regs_t s_ff;
    cal_regs_t nxt_s;

    always_comb
    begin
        nxt_s = s_ff;
        case (s_ff.state)
            CAL_IDLE:
            begin
                if (ctl.cal_start)
                begin
                    nxt_s.state = CAL_RUN;
                    nxt_s.count = '0;
                end
            end
            CAL_RUN:
            begin
                nxt_s.count = s_ff.count + 1'b1;
                if (s_ff.count == CNT_LAST)
                begin
                    nxt_s.state = CAL_IDLE;
                end
            end
            default:
            begin
                nxt_s.state = CAL_IDLE;
            end
        endcase
        // a software reset aborts a running calibration
        if (ctl.clear)
        begin
            nxt_s.state = CAL_IDLE;
            nxt_s.count = '0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            s_ff <= '{state: CAL_IDLE, count: '0};
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign ctl.cal_busy = (s_ff.state == CAL_RUN);
endmodule

// file: afe_mode_decoder.sv
// turns the second configuration register into datapath controls
`timescale 1ns/1ps
module afe_mode_decoder
(
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    afe_ctrl_if.dec   ctl
);
    typedef struct packed
    {
        logic [2:0] input_en;
        logic       reverse;
        logic       mult_en;
        logic [1:0] factor;
        logic       cds;
        logic       even_odd;
    } dec_regs_t;

    dec_regs_t  s_ff;
    dec_regs_t  nxt_s;
    logic [1:0] mode;
    logic [1:0] color;

    assign mode  = ctl.cfg_two[afe_cfg_pkg::CH_MODE_LSB +: 2];
    assign color = ctl.cfg_two[afe_cfg_pkg::COLOR_LSB +: 2];

    always_comb
    begin
        nxt_s = '0;
        // input enables: bit 2 red, bit 1 green, bit 0 blue
        if (mode == afe_cfg_pkg::MODE_THREE)
        begin
            nxt_s.input_en = 3'h7;
        end
        else if (mode == afe_cfg_pkg::MODE_TWO)
        begin
            if (color == afe_cfg_pkg::COLOR_RG)
                nxt_s.input_en = 3'h6;
            else if (color == afe_cfg_pkg::COLOR_GB)
                nxt_s.input_en = 3'h3;
            else if (color == afe_cfg_pkg::COLOR_RB)
                nxt_s.input_en = 3'h5;
        end
        else if (mode == afe_cfg_pkg::MODE_ONE)
        begin
            if (color == afe_cfg_pkg::COLOR_RG)
                nxt_s.input_en = 3'h4;
            else if (color == afe_cfg_pkg::COLOR_GB)
                nxt_s.input_en = 3'h2;
            else if (color == afe_cfg_pkg::COLOR_RB)
                nxt_s.input_en = 3'h1;
        end
        nxt_s.reverse  = ctl.cfg_two[afe_cfg_pkg::ORDER_BIT];
        nxt_s.mult_en  = ctl.cfg_two[afe_cfg_pkg::MULT_BIT];
        // converter clock equals pixel clock times the channel count when multiply is enabled, else pixel clock times one
        nxt_s.factor   = nxt_s.mult_en ? mode
                                       : afe_cfg_pkg::FACTOR_ONE;
        nxt_s.cds      = ctl.cfg_two[afe_cfg_pkg::CDS_BIT];
        nxt_s.even_odd = ctl.cfg_two[afe_cfg_pkg::EVEN_ODD_BIT];
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            s_ff <= '0;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign ctl.input_en = s_ff.input_en;
    assign ctl.reverse  = s_ff.reverse;
    assign ctl.mult_en  = s_ff.mult_en;
    assign ctl.factor   = s_ff.factor;
    assign ctl.cds      = s_ff.cds;
    assign ctl.even_odd = s_ff.even_odd;
endmodule

// file: afe_main_config_regs.sv
// main configuration register bank with apb slave
//
// Chosen here: register access over APB.
`timescale 1ns/1ps

module afe_main_config_regs
(
    input  wire logic        CLOCK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    input  wire logic [3:0]  PSTRB_IN,
    output wire logic [31:0] PRDATA_OUT,
    output wire logic        PREADY_OUT,
    output wire logic        PSLVERR_OUT,
    output wire logic        SERIAL_MODE_25_OUT,
    output wire logic        PLL_AUTOCAL_EN_OUT,
    output wire logic        CAL_ACTIVE_OUT,
    output wire logic        FSM_RESET_OUT,
    output wire logic        AMP_POWER_DOWN_OUT,
    output wire logic        REF_BUF_POWER_DOWN_OUT,
    output wire logic        MASTER_POWER_DOWN_OUT,
    output wire logic        TIMING_RUN_OUT,
    output wire logic [1:0]  CHANNEL_MODE_OUT,
    output wire logic        RED_SENSOR_INPUT_EN_OUT,
    output wire logic        GREEN_SENSOR_INPUT_EN_OUT,
    output wire logic        BLUE_SENSOR_INPUT_EN_OUT,
    output wire logic        REVERSE_ORDER_OUT,
    output wire logic        CLOCK_MULTIPLY_EN_OUT,
    output wire logic [1:0]  CONVERTER_RATE_FACTOR_OUT,
    output wire logic        CDS_MODE_OUT,
    output wire logic        EVEN_ODD_EN_OUT
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic        lock;
        logic [7:0]  cfg_one;
        logic [7:0]  cfg_two;
        logic        soft_fsm;
        logic        soft_all;
        logic        rst_pulse;
        logic        cal_start;
        logic [31:0] prdata;
        logic        pslverr;
    } bank_regs_t;

    localparam bank_regs_t BANK_RST = '{
        lock:      afe_cfg_pkg::LOCK_RST[afe_cfg_pkg::LOCK_BIT],
        cfg_one:   afe_cfg_pkg::CFG_ONE_RST,
        cfg_two:   afe_cfg_pkg::CFG_TWO_RST,
        soft_fsm:  1'b0,
        soft_all:  1'b0,
        rst_pulse: 1'b0,
        cal_start: 1'b0,
        prdata:    32'h0000_0000,
        pslverr:   1'b0
    };

    bank_regs_t  s_ff;
    bank_regs_t  nxt_s;

    logic        setup_phase;
    logic        access_phase;
    logic        wr_take;
    logic        hit_lock;
    logic        hit_one;
    logic        hit_two;
    logic        hit_any;
    logic        low_lane;
    logic [7:0]  wbyte;
    logic [7:0]  cfg_one_view;

    afe_ctrl_if  ctl ();

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    afe_cal_sequencer u_cal
    (
        .clk_in   (CLOCK_IN),
        .rst_n_in (RST_N_IN),
        .ctl      (ctl.cal)
    );

    afe_mode_decoder u_dec
    (
        .clk_in   (CLOCK_IN),
        .rst_n_in (RST_N_IN),
        .ctl      (ctl.dec)
    );

    assign ctl.clear     = s_ff.rst_pulse;
    assign ctl.cal_start = s_ff.cal_start;
    assign ctl.cfg_two   = s_ff.cfg_two;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    assign setup_phase  = PSEL_IN && !PENABLE_IN;
    assign access_phase = PSEL_IN && PENABLE_IN;
    assign wr_take      = access_phase && PWRITE_IN;
    assign low_lane     = PSTRB_IN[0];
    assign wbyte        = PWDATA_IN[7:0];

    always_comb
    begin
        hit_lock = 1'b0;
        hit_one  = 1'b0;
        hit_two  = 1'b0;
        if (PADDR_IN == afe_cfg_pkg::ADDR_LOCK)
        begin
            hit_lock = 1'b1;
        end
        else if (PADDR_IN == afe_cfg_pkg::ADDR_CFG_ONE)
        begin
            hit_one = 1'b1;
        end
        else if (PADDR_IN == afe_cfg_pkg::ADDR_CFG_TWO)
        begin
            hit_two = 1'b1;
        end
    end

    assign hit_any = hit_lock || hit_one || hit_two;

    // ------------------------------------------------------------------
    // readback of config one with live status bits
    // ------------------------------------------------------------------
    always_comb
    begin
        cfg_one_view = s_ff.cfg_one;
        cfg_one_view[afe_cfg_pkg::GAIN_CAL_BIT] =
            ctl.cal_busy || s_ff.cal_start;
        cfg_one_view[afe_cfg_pkg::RST_FSM_BIT] = s_ff.soft_fsm;
        cfg_one_view[afe_cfg_pkg::RST_ALL_BIT] = s_ff.soft_all;
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_s           = s_ff;
        nxt_s.cal_start = 1'b0;
        nxt_s.soft_fsm  = 1'b0;
        nxt_s.soft_all  = 1'b0;
        nxt_s.rst_pulse = s_ff.soft_fsm || s_ff.soft_all;

        // read data is captured in the setup cycle for a zero-wait answer
        if (setup_phase)
        begin
            nxt_s.prdata  = 32'h0000_0000;
            nxt_s.pslverr = !hit_any;
            if (!PWRITE_IN)
            begin
                if (hit_lock)
                begin
                    nxt_s.prdata[afe_cfg_pkg::LOCK_BIT] = s_ff.lock;
                end
                else if (hit_one)
                begin
                    nxt_s.prdata[7:0] = cfg_one_view;
                end
                else if (hit_two)
                begin
                    nxt_s.prdata[7:0] = s_ff.cfg_two;
                end
            end
        end

        if (wr_take && low_lane)
        begin
            if (hit_lock)
            begin
                nxt_s.lock = wbyte[afe_cfg_pkg::LOCK_BIT];
            end
            // configuration bytes only change while unlocked
            else if (hit_one && !s_ff.lock)
            begin
                nxt_s.cfg_one[afe_cfg_pkg::SER_MODE_BIT] =
                    wbyte[afe_cfg_pkg::SER_MODE_BIT];
                nxt_s.cfg_one[afe_cfg_pkg::PLL_CAL_BIT] =
                    wbyte[afe_cfg_pkg::PLL_CAL_BIT];
                nxt_s.cfg_one[afe_cfg_pkg::AMP_PD_BIT] =
                    wbyte[afe_cfg_pkg::AMP_PD_BIT];
                nxt_s.cfg_one[afe_cfg_pkg::REF_PD_BIT] =
                    wbyte[afe_cfg_pkg::REF_PD_BIT];
                nxt_s.cfg_one[afe_cfg_pkg::MASTER_PD_BIT] =
                    wbyte[afe_cfg_pkg::MASTER_PD_BIT];
                // action bits respond only to a written 1
                if (wbyte[afe_cfg_pkg::GAIN_CAL_BIT] && !ctl.cal_busy)
                begin
                    nxt_s.cal_start = 1'b1;
                end
                if (wbyte[afe_cfg_pkg::RST_FSM_BIT])
                begin
                    nxt_s.soft_fsm = 1'b1;
                end
                if (wbyte[afe_cfg_pkg::RST_ALL_BIT])
                begin
                    nxt_s.soft_all = 1'b1;
                end
            end
            else if (hit_two && !s_ff.lock)
            begin
                nxt_s.cfg_two = wbyte;
            end
        end

        // full software reset returns every register to its default
        if (s_ff.soft_all)
        begin
            nxt_s.lock      = BANK_RST.lock;
            nxt_s.cfg_one   = BANK_RST.cfg_one;
            nxt_s.cfg_two   = BANK_RST.cfg_two;
            nxt_s.cal_start = 1'b0;
        end

        // action bits are never stored, they live in their own flags
        nxt_s.cfg_one[afe_cfg_pkg::GAIN_CAL_BIT] = 1'b0;
        nxt_s.cfg_one[afe_cfg_pkg::RST_FSM_BIT]  = 1'b0;
        nxt_s.cfg_one[afe_cfg_pkg::RST_ALL_BIT]  = 1'b0;
    end

    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            s_ff <= BANK_RST;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------------
    assign PREADY_OUT  = access_phase;
    assign PRDATA_OUT  = s_ff.prdata;
    assign PSLVERR_OUT = access_phase && s_ff.pslverr;

    // ------------------------------------------------------------------
    // control outputs
    // ------------------------------------------------------------------
    assign SERIAL_MODE_25_OUT     =
        s_ff.cfg_one[afe_cfg_pkg::SER_MODE_BIT];
    assign PLL_AUTOCAL_EN_OUT     =
        s_ff.cfg_one[afe_cfg_pkg::PLL_CAL_BIT];
    assign CAL_ACTIVE_OUT         = ctl.cal_busy;
    assign FSM_RESET_OUT          = s_ff.rst_pulse;
    assign AMP_POWER_DOWN_OUT     =
        s_ff.cfg_one[afe_cfg_pkg::AMP_PD_BIT];
    assign REF_BUF_POWER_DOWN_OUT =
        s_ff.cfg_one[afe_cfg_pkg::REF_PD_BIT];
    assign MASTER_POWER_DOWN_OUT  =
        s_ff.cfg_one[afe_cfg_pkg::MASTER_PD_BIT];
    assign TIMING_RUN_OUT         = s_ff.lock;

    // ------------------------------------------------------------------
    // datapath outputs
    // ------------------------------------------------------------------
    assign CHANNEL_MODE_OUT =
        s_ff.cfg_two[afe_cfg_pkg::CH_MODE_LSB +: 2];
    assign RED_SENSOR_INPUT_EN_OUT   = ctl.input_en[2];
    assign GREEN_SENSOR_INPUT_EN_OUT = ctl.input_en[1];
    assign BLUE_SENSOR_INPUT_EN_OUT  = ctl.input_en[0];
    assign REVERSE_ORDER_OUT         = ctl.reverse;
    assign CLOCK_MULTIPLY_EN_OUT     = ctl.mult_en;
    assign CONVERTER_RATE_FACTOR_OUT = ctl.factor;
    assign CDS_MODE_OUT              = ctl.cds;
    assign EVEN_ODD_EN_OUT           = ctl.even_odd;

endmodule

// file: afe_main_config_regs_assertions.sv
// concurrent checks on the main configuration register bank ports
`timescale 1ns/1ps
module afe_main_config_regs_assertions
(
    input  wire logic        CLOCK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    input  wire logic [3:0]  PSTRB_IN,
    input  wire logic [31:0] PRDATA_OUT,
    input  wire logic        PREADY_OUT,
    input  wire logic        PSLVERR_OUT,
    input  wire logic        SERIAL_MODE_25_OUT,
    input  wire logic        PLL_AUTOCAL_EN_OUT,
    input  wire logic        CAL_ACTIVE_OUT,
    input  wire logic        FSM_RESET_OUT,
    input  wire logic        AMP_POWER_DOWN_OUT,
    input  wire logic        REF_BUF_POWER_DOWN_OUT,
    input  wire logic        MASTER_POWER_DOWN_OUT,
    input  wire logic        TIMING_RUN_OUT,
    input  wire logic [1:0]  CHANNEL_MODE_OUT,
    input  wire logic        REVERSE_ORDER_OUT,
    input  wire logic        CLOCK_MULTIPLY_EN_OUT,
    input  wire logic [1:0]  CONVERTER_RATE_FACTOR_OUT,
    input  wire logic        CDS_MODE_OUT,
    input  wire logic        EVEN_ODD_EN_OUT
);
    logic acc;
    logic wr1;
    logic wr2;

    // unlocked, strobed writes to the two config registers
    assign acc = PSEL_IN && PENABLE_IN;
    assign wr1 = acc && PWRITE_IN && PSTRB_IN[0] && !TIMING_RUN_OUT
                 && PADDR_IN == afe_cfg_pkg::ADDR_CFG_ONE;
    assign wr2 = acc && PWRITE_IN && PSTRB_IN[0] && !TIMING_RUN_OUT
                 && PADDR_IN == afe_cfg_pkg::ADDR_CFG_TWO;

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_N_IN);

    property p_err;
        acc && !PWRITE_IN && PADDR_IN > afe_cfg_pkg::ADDR_CFG_TWO
        |-> PSLVERR_OUT && PRDATA_OUT == 32'h0 && PREADY_OUT;
    endproperty
    a_err: assert property (p_err) else $error("unmapped read not refused");
    property p_serial;
        wr1 |=> SERIAL_MODE_25_OUT == $past(PWDATA_IN[7]);
    endproperty
    a_serial: assert property (p_serial) else $error("serial mode");
    property p_autocal;
        wr1 |=> PLL_AUTOCAL_EN_OUT == $past(PWDATA_IN[6]);
    endproperty
    a_autocal: assert property (p_autocal) else $error("autocal");
    property p_power;
        wr1 |=> {AMP_POWER_DOWN_OUT, REF_BUF_POWER_DOWN_OUT,
                 MASTER_POWER_DOWN_OUT} == $past(PWDATA_IN[2:0]);
    endproperty
    a_power: assert property (p_power) else $error("power down");
    property p_cal;
        wr1 && PWDATA_IN[5] && PWDATA_IN[4:3] == 2'h0 && !CAL_ACTIVE_OUT
        |-> ##[1:3] CAL_ACTIVE_OUT;
    endproperty
    a_cal: assert property (p_cal) else $error("no calibration");
    property p_fsm;
        wr1 && PWDATA_IN[4] |-> ##[1:2] FSM_RESET_OUT;
    endproperty
    a_fsm: assert property (p_fsm) else $error("no fsm reset");
    property p_pulse;
        $rose(FSM_RESET_OUT) |=> !FSM_RESET_OUT;
    endproperty
    a_pulse: assert property (p_pulse) else $error("reset stuck");
    property p_full;
        wr1 && PWDATA_IN[3] |-> ##[2:4] (TIMING_RUN_OUT && PLL_AUTOCAL_EN_OUT
        && CHANNEL_MODE_OUT == afe_cfg_pkg::MODE_THREE);
    endproperty
    a_full: assert property (p_full) else $error("no full reset");
    property p_locked;
        acc && PWRITE_IN && TIMING_RUN_OUT
        && PADDR_IN == afe_cfg_pkg::ADDR_CFG_TWO |=> $stable(CHANNEL_MODE_OUT);
    endproperty
    a_locked: assert property (p_locked) else $error("locked write");
    property p_mode;
        wr2 |=> CHANNEL_MODE_OUT == $past(PWDATA_IN[7:6]);
    endproperty
    a_mode: assert property (p_mode) else $error("channel mode");
    property p_low;
        wr2 |-> ##2 {REVERSE_ORDER_OUT, CLOCK_MULTIPLY_EN_OUT, CDS_MODE_OUT,
                     EVEN_ODD_EN_OUT} == $past(PWDATA_IN[3:0], 2);
    endproperty
    a_low: assert property (p_low) else $error("low fields");
    property p_factor;
        ($stable(CHANNEL_MODE_OUT) && $stable(CLOCK_MULTIPLY_EN_OUT))[*3]
        |-> CONVERTER_RATE_FACTOR_OUT == (CLOCK_MULTIPLY_EN_OUT ?
            CHANNEL_MODE_OUT : afe_cfg_pkg::FACTOR_ONE);
    endproperty
    a_factor: assert property (p_factor) else $error("rate factor");

    c_cal: cover property (wr1 && PWDATA_IN[5]);
    c_full: cover property (wr1 && PWDATA_IN[3]);
    c_err: cover property (acc && PSLVERR_OUT);
endmodule

bind afe_main_config_regs afe_main_config_regs_assertions i_chk (.*);

// file: tb_afe_main_config_regs.sv
// self-checking bench for the main configuration register bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("FAIL %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module tb_afe_main_config_regs;
    localparam bit [7:0] A0 = afe_cfg_pkg::ADDR_LOCK;
    localparam bit [7:0] A1 = afe_cfg_pkg::ADDR_CFG_ONE;
    localparam bit [7:0] A2 = afe_cfg_pkg::ADDR_CFG_TWO;
    logic        clk, rst_n, psel, pen, pwr, er;
    logic [7:0]  paddr, d;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        rdy, err, ser, pll, cal, fsm, amp, refb, mpd, run;
    logic        red, grn, blu, rev, mul, cds, eo;
    logic [1:0]  chm, fac, m, c;
    logic [2:0]  en;
    int          failures, checks, fsm_n, cal_n, n;

    afe_main_config_regs i_afe_main_config_regs
    (
        .CLOCK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata),
        .PREADY_OUT(rdy), .PSLVERR_OUT(err), .SERIAL_MODE_25_OUT(ser),
        .PLL_AUTOCAL_EN_OUT(pll), .CAL_ACTIVE_OUT(cal),
        .FSM_RESET_OUT(fsm), .AMP_POWER_DOWN_OUT(amp),
        .REF_BUF_POWER_DOWN_OUT(refb), .MASTER_POWER_DOWN_OUT(mpd),
        .TIMING_RUN_OUT(run), .CHANNEL_MODE_OUT(chm),
        .RED_SENSOR_INPUT_EN_OUT(red), .GREEN_SENSOR_INPUT_EN_OUT(grn),
        .BLUE_SENSOR_INPUT_EN_OUT(blu), .REVERSE_ORDER_OUT(rev),
        .CLOCK_MULTIPLY_EN_OUT(mul), .CONVERTER_RATE_FACTOR_OUT(fac),
        .CDS_MODE_OUT(cds), .EVEN_ODD_EN_OUT(eo)
    );

    always #2.5 clk = ~clk;

    // pulse and calibration lengths in cycles
    always @(posedge clk)
    begin
        fsm_n += int'(fsm === 1'b1);
        cal_n += int'(cal === 1'b1);
    end

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one apb transfer, read data and error taken at the ready edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] v, input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= v;
        pstrb <= s;
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 20 && rdy !== 1'b1; n++)
            @(posedge clk);
        if (n == 20)
        begin
            `CHK("ready", 1'b1, rdy)
            wrap_up();
        end
        rd = prdata;
        er = err;
        psel <= 1'b0;
        pen <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        xfer(1'b1, a, {24'h0, v}, 4'hF);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [7:0] v);
        xfer(1'b0, a, 32'h0, 4'hF);
        `CHK(nm, {24'h0, v}, rd)
    endtask

    initial
    begin
        clk = 0;
        rst_n = 0;
        psel = 0;
        pen = 0;
        pwr = 0;
        paddr = 0;
        pwdata = 0;
        pstrb = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rdc("lock", A0, 8'h01);
        rdc("cfg1", A1, 8'h40);
        rdc("cfg2", A2, 8'hC2);
        `CHK("cds", 1'b1, cds)
        wr(A2, 8'h00);
        rdc("cfg2 locked", A2, 8'hC2);
        wr(A0, 8'h00);
        `CHK("run", 1'b0, run)
        wr(A1, 8'h87);
        rdc("cfg1", A1, 8'h87);
        `CHK("cfg1 out", 5'h17, {ser, pll, amp, refb, mpd})
        xfer(1'b1, A1, 32'h0, 4'hE);
        rdc("no strobe", A1, 8'h87);
        `CHK("no pulse", 0, fsm_n)
        for (int i = 0; i < 9; i++)
        begin
            m = 2'(i / 3 + 1);
            c = 2'(i % 3);
            d = {m, c, 4'(i + 4)};
            en = m == 2'h3 ? 3'h7 : m == 2'h1 ? 3'h4 >> c :
                 c == 2'h0 ? 3'h6 : c == 2'h1 ? 3'h3 : 3'h5;
            wr(A2, d);
            rdc("cfg2", A2, d);
            `CHK("mode", m, chm)
            `CHK("inputs", en, {red, grn, blu})
            `CHK("low", d[3:0], {rev, mul, cds, eo})
            `CHK("factor", d[2] ? m : 2'h1, fac)
        end
        wr(A1, 8'h97);
        rdc("cfg1 kept", A1, 8'h87);
        rdc("cfg2 kept", A2, d);
        `CHK("pulses", 1, fsm_n)
        wr(A1, 8'hA7);
        rdc("cal bit", A1, 8'hA7);
        for (n = 0; n < 3000 && cal !== 1'b0; n++)
            @(posedge clk);
        if (n == 3000)
        begin
            `CHK("cal end", 1'b0, cal)
            wrap_up();
        end
        rdc("cal done", A1, 8'h87);
        `CHK("cal len", afe_cfg_pkg::CAL_CYCLES, cal_n)
        rdc("hole", 8'h0C, 8'h00);
        `CHK("hole err", 1'b1, er)
        wr(A1, 8'h8F);
        rdc("lock", A0, 8'h01);
        rdc("cfg1", A1, 8'h40);
        rdc("cfg2", A2, 8'hC2);
        `CHK("pulses", 2, fsm_n)
        wrap_up();
    end
endmodule
